// File: src/ds3_regmap.v
`include "ds3_regmap_consts.vh"

module ds3_regmap #(
  parameter TX_DELAY = `TX_DELAY_BITS,
  parameter RX_DELAY = `RX_DELAY_BITS
) (
  input  wire       ref_clk,            // bit-rate clock
  input  wire       nrst,               // async reset, active low
  input  wire       tx_clk_alive,       // transmit line clock running
  input  wire       rx_clk_alive,       // receive line clock running
  input  wire       ale,                // address latch enable
  input  wire       sel_n,              // chip select, active low
  input  wire       rd_n,               // read strobe, active low
  input  wire       wr_n,               // write strobe, active low
  input  wire [7:0] ad_in,              // multiplexed bus, input side
  output reg  [7:0] ad_out,             // multiplexed bus, output side
  output reg        ad_oe_n,            // low while driving the bus
  input  wire       tx_term_data,       // serial transmit terminal input
  output wire       tx_line_data,       // serial transmit line output
  input  wire       rx_line_data,       // serial receive line input
  output wire       rx_term_data,       // serial receive terminal output
  input  wire [7:0] rx_alarm_in,        // live alarms, 00H
  input  wire [7:0] code_rx_in,         // received alarm code, 06H
  input  wire [7:0] stack_rd_in,        // alarm code stack, 0FH
  input  wire [7:0] lat_pri_set,        // event pulses into 07H
  input  wire [7:0] lat_ext_set,        // event pulses into 09H
  input  wire [7:0] lat_int_set,        // event pulses into 10H
  input  wire [4:0] cnt_evt,            // far_end_block_error_counter, cpar, ppar, fbit, mbit error pulses
  input  wire       line_viol_evt,      // line coding violation pulse
  input  wire       zero_run_evt,       // excessive zeros pulse
  output reg  [7:0] tx_ctl_r,           // 01H
  output reg  [7:0] code_tx_r,          // 05H
  output reg  [7:0] ext_ctl_r,          // 08H
  output reg  [7:0] loop_ctl_r,         // 0CH
  output reg  [7:0] dcode_tx_r,         // 0DH
  output reg  [7:0] opt_ctl_r,          // 0EH
  output reg  [7:0] int_en_r,           // 11H
  output reg  [7:0] err_ctl_r           // 14H
);

  // ************************************************
  // decode helpers
  // ************************************************
  function ext_addr;
    input [7:0] a;
    begin
      ext_addr = (a >= `A_EXT_CTL) && (a <= `A_ERR_CTL);
    end
  endfunction

  function [7:0] cnt_addr;
    input integer i;
    begin
      case (i)
        0:       cnt_addr = `A_FAR_END_BLOCK_ERROR_COUNTER_CNT;
        1:       cnt_addr = `A_CPAR_CNT;
        2:       cnt_addr = `A_PPAR_CNT;
        3:       cnt_addr = `A_FBIT_CNT;
        default: cnt_addr = `A_MBIT_CNT;
      endcase
    end
  endfunction

  function rd_clear;
    input       go;
    input [7:0] a;
    input [7:0] b;
    begin
      rd_clear = go && (a == b);
    end
  endfunction

  // ************************************************
  // serial throughput delay
  // ************************************************
  reg [TX_DELAY-1:0] tx_pipe_r;
  reg [RX_DELAY-1:0] rx_pipe_r;

  // the line clock is this clock, so a bit time is one cycle
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      tx_pipe_r <= {TX_DELAY{1'b0}};
    else
      tx_pipe_r <= {tx_pipe_r[TX_DELAY-2:0], tx_term_data};
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      rx_pipe_r <= {RX_DELAY{1'b0}};
    else
      rx_pipe_r <= {rx_pipe_r[RX_DELAY-2:0], rx_line_data};
  end

  assign tx_line_data = tx_pipe_r[TX_DELAY-1];
  assign rx_term_data = rx_pipe_r[RX_DELAY-1];

  // ************************************************
  // bus strobe tracking
  // ************************************************
  reg       ale_q_r;
  reg       rd_n_q_r;
  reg       wr_n_q_r;
  reg [7:0] addr_r;
  reg [7:0] wdat_r;

  wire bus_ok  = tx_clk_alive | rx_clk_alive;
  wire ext_on  = code_tx_r[`B_EXT_MAP_EN];
  wire rd_hit  = rd_n_q_r & ~rd_n & ~sel_n & bus_ok;
  wire wr_hit  = ~wr_n_q_r & wr_n & ~sel_n & bus_ok;
  wire acc_ok  = ~ext_addr(addr_r) | ext_on;
  wire rd_go   = rd_hit & acc_ok;
  wire wr_go   = wr_hit & acc_ok;
  wire reg_rst = wr_go & (addr_r == `A_EXT_CTL) & wdat_r[`B_REG_RESET];

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ale_q_r  <= 1'b0;
      rd_n_q_r <= 1'b1;
      wr_n_q_r <= 1'b1;
      addr_r   <= `RST_BYTE;
      wdat_r   <= `RST_BYTE;
    end else begin
      ale_q_r  <= ale;
      rd_n_q_r <= rd_n;
      wr_n_q_r <= wr_n;
      if (ale_q_r && !ale)
        addr_r <= ad_in;
      // data may leave right at the strobe's rise, so hold the last low-phase value
      if (!wr_n)
        wdat_r <= ad_in;
    end
  end

  // ************************************************
  // saturating counters
  // ************************************************
  reg  [7:0]  cnt_r [0:4];
  reg  [15:0] viol_r;
  wire [4:0]  cnt_clr;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_cnt
      assign cnt_clr[g] = rd_clear(rd_go, addr_r, cnt_addr(g));
      // an event in the read cycle restarts at one, never lost
      always @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
          cnt_r[g] <= `RST_BYTE;
        else if (reg_rst)
          cnt_r[g] <= `RST_BYTE;
        else if (cnt_clr[g])
          cnt_r[g] <= {7'h00, cnt_evt[g]};
        else if (cnt_evt[g] && cnt_r[g] != `SAT_BYTE)
          cnt_r[g] <= cnt_r[g] + 8'h01;
      end
    end
  endgenerate

  wire viol_evt = (line_viol_evt & err_ctl_r[`B_VIOL_CNT_EN]) |
                  (zero_run_evt & err_ctl_r[`B_ZRUN_CNT_EN]);
  wire clr_lo   = rd_clear(rd_go, addr_r, `A_VIOL_LO);
  wire clr_hi   = rd_clear(rd_go, addr_r, `A_VIOL_HI);
  reg [15:0] viol_nxt;

  always @* begin
    viol_nxt = viol_r;
    if (clr_lo)
      viol_nxt[7:0] = `RST_BYTE;
    if (clr_hi)
      viol_nxt[15:8] = `RST_BYTE;
    if (viol_evt && viol_nxt != `SAT_WORD)
      viol_nxt = viol_nxt + 16'h0001;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      viol_r <= `RST_WORD;
    else if (reg_rst)
      viol_r <= `RST_WORD;
    else
      viol_r <= viol_nxt;
  end

  // ************************************************
  // latched alarms
  // ************************************************
  reg [7:0] lat_pri_r;
  reg [7:0] lat_ext_r;
  reg [7:0] lat_int_r;

  wire clr_pri = rd_clear(rd_go, addr_r, `A_LAT_PRI);
  wire clr_ext = rd_clear(rd_go, addr_r, `A_LAT_EXT);
  wire clr_int = rd_clear(rd_go, addr_r, `A_LAT_INT);

  // new events win over the read clear; bus writes touch these only through the register reset bit
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      lat_pri_r <= `RST_BYTE;
    else if (reg_rst)
      lat_pri_r <= `RST_BYTE;
    else
      lat_pri_r <= (clr_pri ? `RST_BYTE : lat_pri_r) | lat_pri_set;
  end

  // unused positions never latch, so they cannot leak into a read
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      lat_ext_r <= `RST_BYTE;
    else if (reg_rst)
      lat_ext_r <= `RST_BYTE;
    else
      lat_ext_r <= (clr_ext ? `RST_BYTE : lat_ext_r) | (lat_ext_set & `M_LAT_EXT);
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      lat_int_r <= `RST_BYTE;
    else if (reg_rst)
      lat_int_r <= `RST_BYTE;
    else
      lat_int_r <= (clr_int ? `RST_BYTE : lat_int_r) | lat_int_set;
  end

  // ************************************************
  // read/write control registers
  // ************************************************
  // only the listed read/write offsets decode; other writes fall through
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_ctl_r   <= `RST_BYTE;
      code_tx_r  <= `RST_BYTE;
      ext_ctl_r  <= `RST_BYTE;
      loop_ctl_r <= `RST_BYTE;
      dcode_tx_r <= `RST_BYTE;
      opt_ctl_r  <= `RST_BYTE;
      int_en_r   <= `RST_BYTE;
      err_ctl_r  <= `RST_BYTE;
    end else if (reg_rst) begin
      // the reset bit itself does not stay set; 05H keeps the map open
      tx_ctl_r   <= `RST_BYTE;
      ext_ctl_r  <= `RST_BYTE;
      loop_ctl_r <= `RST_BYTE;
      dcode_tx_r <= `RST_BYTE;
      opt_ctl_r  <= `RST_BYTE;
      int_en_r   <= `RST_BYTE;
      err_ctl_r  <= `RST_BYTE;
    end else if (wr_go) begin
      case (addr_r)
        `A_TX_CTL:   tx_ctl_r   <= wdat_r;
        `A_CODE_TX:  code_tx_r  <= wdat_r;
        `A_EXT_CTL:  ext_ctl_r  <= wdat_r;
        `A_LOOP_CTL: loop_ctl_r <= wdat_r;
        `A_DCODE_TX: dcode_tx_r <= wdat_r;
        `A_OPT_CTL:  opt_ctl_r  <= wdat_r;
        `A_INT_EN:   int_en_r   <= wdat_r;
        `A_ERR_CTL:  err_ctl_r  <= wdat_r;
        default:     ;
      endcase
    end
  end

  // ************************************************
  // read mux and bus drive
  // ************************************************
  reg [7:0] rd_nxt;

  always @* begin
    case (addr_r)
      `A_RX_ALARM: rd_nxt = rx_alarm_in;
      `A_TX_CTL:   rd_nxt = tx_ctl_r;
      `A_FAR_END_BLOCK_ERROR_COUNTER_CNT: rd_nxt = cnt_r[0];
      `A_CPAR_CNT: rd_nxt = cnt_r[1];
      `A_PPAR_CNT: rd_nxt = cnt_r[2];
      `A_CODE_TX:  rd_nxt = code_tx_r;
      `A_CODE_RX:  rd_nxt = code_rx_in;
      `A_LAT_PRI:  rd_nxt = lat_pri_r;
      `A_EXT_CTL:  rd_nxt = ext_ctl_r;
      `A_LAT_EXT:  rd_nxt = lat_ext_r & `M_LAT_EXT;
      `A_FBIT_CNT: rd_nxt = cnt_r[3];
      `A_MBIT_CNT: rd_nxt = cnt_r[4];
      `A_LOOP_CTL: rd_nxt = loop_ctl_r;
      `A_DCODE_TX: rd_nxt = dcode_tx_r;
      `A_OPT_CTL:  rd_nxt = opt_ctl_r;
      `A_STACK_RD: rd_nxt = stack_rd_in;
      `A_LAT_INT:  rd_nxt = lat_int_r;
      `A_INT_EN:   rd_nxt = int_en_r;
      `A_VIOL_LO:  rd_nxt = viol_r[7:0];
      `A_VIOL_HI:  rd_nxt = viol_r[15:8];
      `A_ERR_CTL:  rd_nxt = err_ctl_r;
      default:     rd_nxt = `RST_BYTE;
    endcase
    if (!acc_ok)
      rd_nxt = `RST_BYTE;
  end

  // data is sampled once at the strobe's fall and held for the whole read
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ad_out  <= `RST_BYTE;
      ad_oe_n <= 1'b1;
    end else if (rd_hit) begin
      ad_out  <= rd_nxt;
      ad_oe_n <= 1'b0;
    end else if (rd_n || sel_n) begin
      ad_oe_n <= 1'b1;
    end
  end

endmodule

// File: src/ds3_regmap_consts.vh
`ifndef DS3_REGMAP_CONSTS_VH
`define DS3_REGMAP_CONSTS_VH
// Functional notes
// - In serial terminal mode transmit terminal data reaches the transmit line output three bit times later.
// - In serial terminal mode receive line data reaches the receive terminal output two bit times later.
// - Power-on contents are undefined, so software writes the register reset bit at 08H bit 1 to clear them; the code leaves 05H unchanged by it.
// - Addresses 08H to 14H are reachable only while the extended map enable bit at 05H bit 7 is 1.
// - Every error counter saturates at its maximum, and a read returns the value and then clears it.
// - Latched alarm bits hold an event until the register is read, and the read clears them.
// - Unused bits of read-only registers always read as zero.
// - The line violation and zero run counter is 16 bits, low byte at 12H and high byte at 13H, both saturating and clear-on-read.
// - The bus works only while the transmit or receive line clock runs, and the host makes sure one does.

// ************************************************
// register offsets
// ************************************************
`define A_RX_ALARM    8'h00
`define A_TX_CTL      8'h01
`define A_FAR_END_BLOCK_ERROR_COUNTER_CNT    8'h02
`define A_CPAR_CNT    8'h03
`define A_PPAR_CNT    8'h04
`define A_CODE_TX     8'h05
`define A_CODE_RX     8'h06
`define A_LAT_PRI     8'h07
`define A_EXT_CTL     8'h08
`define A_LAT_EXT     8'h09
`define A_FBIT_CNT    8'h0a
`define A_MBIT_CNT    8'h0b
`define A_LOOP_CTL    8'h0c
`define A_DCODE_TX    8'h0d
`define A_OPT_CTL     8'h0e
`define A_STACK_RD    8'h0f
`define A_LAT_INT     8'h10
`define A_INT_EN      8'h11
`define A_VIOL_LO     8'h12
`define A_VIOL_HI     8'h13
`define A_ERR_CTL     8'h14

// ************************************************
// fields and reset values
// ************************************************
`define B_EXT_MAP_EN  7
`define B_REG_RESET   1
`define B_VIOL_CNT_EN 0
`define B_ZRUN_CNT_EN 1
`define M_LAT_EXT     8'ha1
`define RST_BYTE      8'h00
`define RST_WORD      16'h0000
`define SAT_BYTE      8'hff
`define SAT_WORD      16'hffff

// ************************************************
// timing
// ************************************************
`define BIT_TIME_PS   22350
`define TX_DELAY_BITS 3
`define RX_DELAY_BITS 2
`endif

// File: tb/ds3_regmap_sva.sv
`include "ds3_regmap_consts.vh"
module ds3_regmap_sva (
  input wire       ref_clk,      // clk
  input wire       nrst,         // rst
  input wire       tx_clk_alive, // tx clk
  input wire       rx_clk_alive, // rx clk
  input wire       ale,          // latch
  input wire       sel_n,        // select
  input wire       rd_n,         // read
  input wire       wr_n,         // write
  input wire [7:0] ad_in,        // bus in
  input wire [7:0] ad_out,       // bus out
  input wire       ad_oe_n,      // drive
  input wire       tx_term_data, // tx in
  input wire       tx_line_data, // tx out
  input wire       rx_line_data, // rx in
  input wire       rx_term_data, // rx out
  input wire [7:0] tx_ctl_r,     // 01H
  input wire [7:0] code_tx_r,    // 05H
  input wire [7:0] ext_ctl_r,    // 08H
  input wire [7:0] loop_ctl_r    // 0CH
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  reg [1:0] up_r;
  reg       ale_r, rd_r, wr_r;
  reg [7:0] adr_r, wd_r;
  wire alive = tx_clk_alive | rx_clk_alive;
  wire rd_tk = ~rd_n & rd_r & ~sel_n & alive;
  wire wr_tk = wr_n & ~wr_r & ~sel_n & alive;
  wire ext_a = (adr_r >= `A_EXT_CTL) && (adr_r <= `A_ERR_CTL);
  // ****************************************
  // bus decode mirror
  // ****************************************
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      up_r <= 2'd0;
      ale_r <= 1'b0;
      rd_r <= 1'b1;
      wr_r <= 1'b1;
      adr_r <= 8'h00;
      wd_r <= 8'h00;
    end else begin
      if (up_r != 2'd3) up_r <= up_r + 2'd1;
      ale_r <= ale;
      rd_r <= rd_n;
      wr_r <= wr_n;
      if (ale_r && !ale) adr_r <= ad_in;
      if (!wr_n) wd_r <= ad_in;
    end
  end
  tx_delay_a: assert property (up_r == 2'd3 |-> tx_line_data == $past(tx_term_data, 3)) else $error("tx delay");
  rx_delay_a: assert property (up_r == 2'd3 |-> rx_term_data == $past(rx_line_data, 2)) else $error("rx delay");
  rd_drive_a: assert property (rd_tk |=> !ad_oe_n) else $error("no read drive");
  oe_release_a: assert property ((rd_n || sel_n) |=> ad_oe_n) else $error("drive held");
  no_clk_a: assert property (!alive && ad_oe_n |=> ad_oe_n) else $error("drive without clock");
  map_enable_a: assert property (wr_tk && adr_r == `A_CODE_TX |=> code_tx_r == $past(wd_r)) else $error("05H write");
  ext_write_a: assert property (wr_tk && ext_a && !code_tx_r[7] |=> $stable(ext_ctl_r) && $stable(loop_ctl_r))
    else $error("ext write not ignored");
  ext_read_a: assert property (rd_tk && ext_a && !code_tx_r[7] |=> ad_out == 8'h00) else $error("ext read not zero");
  reg_reset_a: assert property (wr_tk && adr_r == `A_EXT_CTL && code_tx_r[7] && wd_r[`B_REG_RESET]
    |=> ext_ctl_r == 8'h00 && tx_ctl_r == 8'h00 && loop_ctl_r == 8'h00) else $error("reg reset");
  cover property (rd_tk);
  cover property (wr_tk && ext_a);
  cover property (!alive && !rd_n);
endmodule
bind ds3_regmap ds3_regmap_sva u_sva (.ref_clk, .nrst, .tx_clk_alive, .rx_clk_alive, .ale, .sel_n, .rd_n, .wr_n,
  .ad_in, .ad_out, .ad_oe_n, .tx_term_data, .tx_line_data, .rx_line_data, .rx_term_data, .tx_ctl_r, .code_tx_r,
  .ext_ctl_r, .loop_ctl_r);

// File: tb/ds3_host.sv
module ds3_host (
  input  wire        ref_clk, // clk
  input  wire  [7:0] ad_out,  // bus out
  input  wire        ad_oe_n, // drive
  output logic       ale,     // latch
  output logic       sel_n,   // select
  output logic       rd_n,    // read
  output logic       wr_n,    // write
  output logic [7:0] ad_in    // bus in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ale = 1'b0;
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ad_in = 8'h00;
  end
  // released bus shows the inverse, never a stale value
  task automatic rd(input [7:0] a, output [8:0] d);
    @(negedge ref_clk) {ale, ad_in} = {1'b1, a};
    @(negedge ref_clk) ale = 1'b0;
    @(negedge ref_clk) {rd_n, sel_n, ad_in} = {2'b00, ~a};
    repeat (2) @(negedge ref_clk);
    d = {ad_oe_n, ad_out};
    {rd_n, sel_n} = 2'b11;
    @(negedge ref_clk);
  endtask
  task automatic wr(input [7:0] a, input [7:0] v);
    @(negedge ref_clk) {ale, ad_in} = {1'b1, a};
    @(negedge ref_clk) ale = 1'b0;
    @(negedge ref_clk) {wr_n, sel_n, ad_in} = {2'b00, v};
    @(negedge ref_clk) wr_n = 1'b1;
    @(negedge ref_clk) {sel_n, ad_in} = {1'b1, ~v};
  endtask
endmodule

// File: tb/test_ds3_framer_register_map.sv
`include "ds3_regmap_consts.vh"
module test_ds3_framer_register_map;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, nrst, tx_clk_alive, rx_clk_alive, tx_term_data, rx_line_data, line_viol_evt, zero_run_evt;
  logic [7:0] rx_alarm_in, code_rx_in, stack_rd_in, lat_pri_set, lat_ext_set, lat_int_set, ad_in, v, rwv[6];
  logic [4:0] cnt_evt;
  logic [2:0] txh;
  logic [1:0] rxh;
  logic [8:0] r;
  wire        ale, sel_n, rd_n, wr_n, ad_oe_n, tx_line_data, rx_term_data;
  wire  [7:0] ad_out, tx_ctl_r, code_tx_r, ext_ctl_r, loop_ctl_r, dcode_tx_r, opt_ctl_r, int_en_r, err_ctl_r;
  int         n_mismatch, samples_checked, n;
  const logic [7:0] rwa[6] = '{8'h01, 8'h0c, 8'h0d, 8'h0e, 8'h11, 8'h14};
  const logic [7:0] cna[5] = '{8'h02, 8'h03, 8'h04, 8'h0a, 8'h0b};
  ds3_regmap i_ds3_regmap (.ref_clk, .nrst, .tx_clk_alive, .rx_clk_alive, .ale, .sel_n, .rd_n, .wr_n, .ad_in,
    .ad_out, .ad_oe_n, .tx_term_data, .tx_line_data, .rx_line_data, .rx_term_data, .rx_alarm_in, .code_rx_in,
    .stack_rd_in, .lat_pri_set, .lat_ext_set, .lat_int_set, .cnt_evt, .line_viol_evt, .zero_run_evt, .tx_ctl_r,
    .code_tx_r, .ext_ctl_r, .loop_ctl_r, .dcode_tx_r, .opt_ctl_r, .int_en_r, .err_ctl_r);
  ds3_host u_host (.ref_clk, .ad_out, .ad_oe_n, .ale, .sel_n, .rd_n, .wr_n, .ad_in);
  function automatic [7:0] sat8(input int k);
    return (k > 255) ? 8'hff : k[7:0];
  endfunction
  task automatic chk(input [8:0] got, input [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input [7:0] a, input [7:0] e);
    u_host.rd(a, r);
    chk(r, {1'b0, e});
  endtask
  task automatic evt(input int k, input [4:0] c, input lv, input zr);
    repeat (k) begin
      @(negedge ref_clk) {cnt_evt, line_viol_evt, zero_run_evt} = {c, lv, zr};
      @(negedge ref_clk) {cnt_evt, line_viol_evt, zero_run_evt} = 7'h00;
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    end_sim;
  end
  // serial pipes checked every bit, random data both ways
  always @(negedge ref_clk) if (nrst) begin
    chk({8'h00, tx_line_data}, {8'h00, txh[2]});
    chk({8'h00, rx_term_data}, {8'h00, rxh[1]});
    tx_term_data = $urandom;
    rx_line_data = $urandom;
    txh = {txh[1:0], tx_term_data};
    rxh = {rxh[0], rx_line_data};
  end
  initial begin
    v = $urandom(5);
    {nrst, tx_clk_alive, rx_clk_alive, tx_term_data, rx_line_data, line_viol_evt, zero_run_evt} = 7'b0110000;
    {rx_alarm_in, code_rx_in, stack_rd_in, lat_pri_set, lat_ext_set, lat_int_set, cnt_evt} = '0;
    {txh, rxh} = '0;
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (10) @(negedge ref_clk);
    u_host.wr(`A_CODE_TX, 8'h80);
    u_host.wr(`A_EXT_CTL, 8'h02);
    rdc(`A_EXT_CTL, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rwv[i] = $urandom & ((rwa[i] == `A_OPT_CTL) ? 8'hbf : 8'hff);
      u_host.wr(rwa[i], rwv[i]);
      rdc(rwa[i], rwv[i]);
    end
    rx_alarm_in = $urandom;
    code_rx_in = $urandom;
    stack_rd_in = $urandom;
    u_host.wr(`A_RX_ALARM, ~rx_alarm_in);
    rdc(`A_RX_ALARM, rx_alarm_in);
    rdc(`A_CODE_RX, code_rx_in);
    rdc(`A_STACK_RD, stack_rd_in);
    rdc(`A_CODE_TX, 8'h80);
    u_host.wr(`A_CODE_TX, 8'h00);
    u_host.wr(`A_LOOP_CTL, ~rwv[1]);
    rdc(`A_LOOP_CTL, 8'h00);
    u_host.wr(`A_CODE_TX, 8'h80);
    rdc(`A_LOOP_CTL, rwv[1]);
    for (int i = 0; i < 5; i++) begin
      n = (i == 3) ? 300 : $urandom_range(40, 1);
      evt(n, 5'd1 << i, 1'b0, 1'b0);
      rdc(cna[i], sat8(n));
      rdc(cna[i], 8'h00);
    end
    u_host.wr(`A_ERR_CTL, 8'h03);
    evt(200, 5'd0, 1'b1, 1'b0);
    evt(100, 5'd0, 1'b0, 1'b1);
    rdc(`A_VIOL_LO, 8'h2c);
    rdc(`A_VIOL_HI, 8'h01);
    rdc(`A_VIOL_LO, 8'h00);
    rdc(`A_VIOL_HI, 8'h00);
    v = $urandom;
    @(negedge ref_clk) {lat_pri_set, lat_ext_set} = {v, 8'hff};
    @(negedge ref_clk) {lat_pri_set, lat_ext_set} = 16'h0000;
    u_host.wr(`A_LAT_PRI, 8'hff);
    rdc(`A_LAT_PRI, v);
    rdc(`A_LAT_PRI, 8'h00);
    rdc(`A_LAT_EXT, `M_LAT_EXT);
    rdc(`A_LAT_EXT, 8'h00);
    v = $urandom;
    @(negedge ref_clk) lat_int_set = v;
    @(negedge ref_clk) lat_int_set = 8'h00;
    rdc(`A_LAT_INT, v);
    rdc(`A_LAT_INT, 8'h00);
    rdc(8'h20, 8'h00);
    {tx_clk_alive, rx_clk_alive} = 2'b00;
    u_host.wr(`A_TX_CTL, ~rwv[0]);
    u_host.rd(`A_TX_CTL, r);
    chk({8'h00, r[8]}, 9'h001);
    chk({1'b0, tx_ctl_r}, {1'b0, rwv[0]});
    rx_clk_alive = 1'b1;
    rdc(`A_TX_CTL, rwv[0]);
    @(negedge ref_clk) lat_int_set = 8'hff;
    @(negedge ref_clk) lat_int_set = 8'h00;
    evt(3, 5'h1f, 1'b1, 1'b1);
    u_host.wr(`A_EXT_CTL, 8'h02);
    rdc(`A_TX_CTL, 8'h00);
    rdc(`A_LAT_INT, 8'h00);
    rdc(`A_FAR_END_BLOCK_ERROR_COUNTER_CNT, 8'h00);
    rdc(`A_VIOL_LO, 8'h00);
    rdc(`A_CODE_TX, 8'h80);
    end_sim;
  end
endmodule
